// [core/clamp_pkg.sv]
package clamp_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CLAMP_CONFIGURATION   = 8'h18;
    localparam logic [7:0] ADDR_CLAMP_PLACEMENT_COUNT = 8'h19;
    localparam logic [7:0] ADDR_CLAMP_DURATION_COUNT  = 8'h1A;

    // reset values
    localparam logic [7:0] RST_CLAMP_CONFIGURATION    = 8'h00;
    localparam logic [7:0] RST_CLAMP_PLACEMENT_COUNT  = 8'h04;
    localparam logic [7:0] RST_CLAMP_DURATION_COUNT   = 8'h28;

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    localparam int CFG_POL_OVR_BIT  = 7;  // polarity field, upper bit
    localparam int CFG_POL_VAL_BIT  = 6;  // polarity field, lower bit
    localparam int CFG_SRC_EXT_BIT  = 4;  // 1: external clamp pin
    localparam int CFG_SEL_RED_BIT  = 3;  // 1: midscale, 0: ground
    localparam int CFG_SEL_GRN_BIT  = 2;
    localparam int CFG_SEL_BLU_BIT  = 1;
    localparam int CFG_STATE_BIT    = 0;  // reads live clamp level

    // ----------------------------------------------------------------
    // clamp targets and timing
    // ----------------------------------------------------------------
    localparam logic [9:0] TARGET_MIDSCALE = 10'h200;
    localparam logic [9:0] TARGET_GROUND   = 10'h000;
    localparam logic [4:0] CAL_CYCLES      = 5'h10;  // data clock cycles

    typedef logic [7:0] byte_type;
    typedef logic [9:0] code_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_HOLD = 2'b10
    } gen_state_type;

endpackage

// [core/clamp_timing_generator.sv]
`timescale 1ns/10ps
// Functional notes
// - Clamp source bit at one takes clamp timing from the external pin.
// - The two-bit polarity field sets the active level of the pin.
// - Internal clamp starts the placement count of pixels after sync end.
// - Internal clamp stays active for the duration count, then ends.
// - Placement and duration are unsigned 8-bit counts, 0 to 255 pixels.
// - Each channel selects a midscale (512) or ground clamp target.
// - A ground-clamped channel aims at output code zero while clamping.
// - Offset correction runs 16 cycles, starting one cycle after clamp ends.
module clamp_timing_generator (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               srst,
    // register port from the serial control decoder
    input  wire clamp_pkg::byte_type reg_addr,
    input  wire clamp_pkg::byte_type reg_wdata,
    input  wire logic               reg_wr,
    output clamp_pkg::byte_type     reg_rdata,
    // video source pins
    input  wire logic               hsync_pin,
    input  wire logic               clamp_pin,
    // clamp outputs to the converter channels
    output logic                    clamp_out,
    output logic                    offset_cal_active,
    output clamp_pkg::code_type     clamp_target_red,
    output clamp_pkg::code_type     clamp_target_green,
    output clamp_pkg::code_type     clamp_target_blue
);
    import clamp_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers and sync edge
    // ----------------------------------------------------------------
    logic          hs_sync;
    logic          clamp_sync;
    logic          hs_prev_reg;
    logic          hs_fall;
    byte_type      cfg_reg;
    byte_type      place_reg;
    byte_type      dur_reg;
    gen_state_type state_reg;
    gen_state_type state_next;
    byte_type      cnt_reg;
    byte_type      cnt_next;
    logic          src_ext;
    logic          act_high;
    logic          ext_active;
    logic          clamp_d_reg;
    logic [4:0]    cal_cnt_reg;

    pin_sync u_hsync_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .din      (hsync_pin),
        .dout     (hs_sync)
    );
    pin_sync u_clamp_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .din      (clamp_pin),
        .dout     (clamp_sync)
    );

    // hsync is taken active high; its trailing edge is the fall
    always_ff @(posedge core_clk) begin
        hs_prev_reg <= srst ? 1'b0 : hs_sync;
    end
    assign hs_fall = hs_prev_reg & ~hs_sync;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // eight-bit configuration and count registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_reg   <= RST_CLAMP_CONFIGURATION;
            place_reg <= RST_CLAMP_PLACEMENT_COUNT;
            dur_reg   <= RST_CLAMP_DURATION_COUNT;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CLAMP_CONFIGURATION:   cfg_reg   <= reg_wdata;
                ADDR_CLAMP_PLACEMENT_COUNT: place_reg <= reg_wdata;
                ADDR_CLAMP_DURATION_COUNT:  dur_reg   <= reg_wdata;
                default:                    ;
            endcase
        end
    end

    // read data; config bit 0 shows the live clamp, unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                ADDR_CLAMP_CONFIGURATION:
                    reg_rdata <= {cfg_reg[7:1], clamp_out};
                ADDR_CLAMP_PLACEMENT_COUNT: reg_rdata <= place_reg;
                ADDR_CLAMP_DURATION_COUNT:  reg_rdata <= dur_reg;
                default:                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // internal clamp generator
    // ----------------------------------------------------------------
    // placement, hold and restart
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (hs_fall) begin
            if (place_reg != 8'h00) begin
                state_next = ST_WAIT;
                cnt_next   = place_reg;
            end else if (dur_reg != 8'h00) begin
                state_next = ST_HOLD;
                cnt_next   = dur_reg;
            end else begin
                state_next = ST_IDLE;
            end
        end else begin
            case (state_reg)
                ST_IDLE: state_next = ST_IDLE;
                ST_WAIT: begin
                    if (cnt_reg == 8'h01) begin
                        state_next = (dur_reg != 8'h00) ? ST_HOLD : ST_IDLE;
                        cnt_next   = dur_reg;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
                ST_HOLD: begin
                    if (cnt_reg == 8'h01) begin
                        state_next = ST_IDLE;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // clamp source select
    // ----------------------------------------------------------------
    // polarity: upper bit set uses lower bit, else active high
    assign act_high   = cfg_reg[CFG_POL_OVR_BIT] ? cfg_reg[CFG_POL_VAL_BIT]
                                                 : 1'b1;
    assign ext_active = act_high ? clamp_sync : ~clamp_sync;
    assign src_ext    = cfg_reg[CFG_SRC_EXT_BIT];

    // pin only when source bit set
    always_ff @(posedge core_clk) begin
        clamp_out <= srst ? 1'b0
                   : src_ext ? ext_active : (state_next == ST_HOLD);
    end

    // ----------------------------------------------------------------
    // channel targets and offset correction window
    // ----------------------------------------------------------------
    // midscale or ground per channel
    always_ff @(posedge core_clk) begin
        if (srst) begin
            clamp_target_red   <= TARGET_GROUND;
            clamp_target_green <= TARGET_GROUND;
            clamp_target_blue  <= TARGET_GROUND;
        end else begin
            clamp_target_red   <= cfg_reg[CFG_SEL_RED_BIT] ?
                                  TARGET_MIDSCALE : TARGET_GROUND;
            clamp_target_green <= cfg_reg[CFG_SEL_GRN_BIT] ?
                                  TARGET_MIDSCALE : TARGET_GROUND;
            clamp_target_blue  <= cfg_reg[CFG_SEL_BLU_BIT] ?
                                  TARGET_MIDSCALE : TARGET_GROUND;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            clamp_d_reg <= 1'b0;
            cal_cnt_reg <= 5'h00;
        end else begin
            clamp_d_reg <= clamp_out;
            if (clamp_d_reg && !clamp_out) begin
                cal_cnt_reg <= CAL_CYCLES;
            end else if (cal_cnt_reg != 5'h00) begin
                cal_cnt_reg <= cal_cnt_reg - 5'h01;
            end
        end
    end
    assign offset_cal_active = (cal_cnt_reg != 5'h00);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [8:0] since_edge_reg;  // cycles since last sync trailing edge
    logic [8:0] wr_age_reg;      // cycles since last register write
    logic [4:0] cal_len_reg;     // length of current correction run
    always_ff @(posedge core_clk) begin
        if (srst) begin
            since_edge_reg <= 9'h1FF;
            wr_age_reg     <= 9'h000;
            cal_len_reg    <= 5'h00;
        end else begin
            since_edge_reg <= hs_fall ? 9'h001 : (since_edge_reg == 9'h1FF)
                              ? 9'h1FF : since_edge_reg + 9'h001;
            wr_age_reg     <= reg_wr ? 9'h000 : (wr_age_reg == 9'h1FF)
                              ? 9'h1FF : wr_age_reg + 9'h001;
            if (clamp_d_reg && !clamp_out) begin
                cal_len_reg <= 5'h00;
            end else if (offset_cal_active) begin
                cal_len_reg <= cal_len_reg + 5'h01;
            end
        end
    end

    // one clock domain, so one clock and reset for every check
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_ext_source;
        (src_ext && $past(src_ext) && act_high && $past(act_high))
            |-> clamp_out == $past(clamp_sync);
    endproperty
    a_ext_source: assert property (p_ext_source)
        else $error("external clamp does not follow the pin");
    property p_ext_low_pol;
        (src_ext && $past(src_ext) && !act_high && $past(!act_high))
            |-> clamp_out != $past(clamp_sync);
    endproperty
    a_ext_low_pol: assert property (p_ext_low_pol)
        else $error("active-low clamp pin not inverted");
    property p_place_start;
        ($rose(clamp_out) && !src_ext && wr_age_reg > since_edge_reg)
            |-> since_edge_reg == {1'b0, place_reg} + 9'h001;
    endproperty
    a_place_start: assert property (p_place_start)
        else $error("internal clamp started at wrong pixel");
    property p_dur_end;
        ($fell(clamp_out) && !src_ext && wr_age_reg > since_edge_reg
            && since_edge_reg > {1'b0, place_reg} + 9'h001)
            |-> since_edge_reg ==
                {1'b0, place_reg} + {1'b0, dur_reg} + 9'h001;
    endproperty
    a_dur_end: assert property (p_dur_end)
        else $error("internal clamp held for wrong length");
    property p_int_ignores_pin;
        (!src_ext && $past(!src_ext)) |-> clamp_out == (state_reg == ST_HOLD);
    endproperty
    a_int_ignores_pin: assert property (p_int_ignores_pin)
        else $error("internal mode clamp differs from generator");
    property p_restart;
        (hs_fall && place_reg != 8'h00)
            |=> state_reg == ST_WAIT && cnt_reg == $past(place_reg);
    endproperty
    a_restart: assert property (p_restart)
        else $error("sync edge did not restart placement");
    property p_ground_target;
        (clamp_out && !cfg_reg[CFG_SEL_GRN_BIT]
            && $past(!cfg_reg[CFG_SEL_GRN_BIT]))
            |-> clamp_target_green == TARGET_GROUND;
    endproperty
    a_ground_target: assert property (p_ground_target)
        else $error("ground channel target not zero");
    property p_mid_target;
        $rose(cfg_reg[CFG_SEL_RED_BIT]) |=>
            clamp_target_red == TARGET_MIDSCALE;
    endproperty
    a_mid_target: assert property (p_mid_target)
        else $error("midscale target not 512");
    property p_cal_len;
        $fell(offset_cal_active) |-> $past(cal_len_reg) == 5'h0F;
    endproperty
    a_cal_len: assert property (p_cal_len)
        else $error("offset correction window not 16 cycles");
    property p_cal_follows;
        $fell(clamp_out) |=> offset_cal_active [*8];
    endproperty
    a_cal_follows: assert property (p_cal_follows)
        else $error("correction did not follow clamp end");

    c_cov_int: cover property (!src_ext && $rose(clamp_out));
    c_cov_ext: cover property (src_ext && $fell(clamp_out));
    c_cov_restart: cover property (hs_fall && state_reg == ST_HOLD);
endmodule

// [core/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // asynchronous level in, synchronised level out
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;

    // two stages; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_reg <= 1'b0;
            dout     <= 1'b0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import clamp_pkg::*;
    logic        core_clk;
    logic        srst;
    byte_type    reg_addr;
    byte_type    reg_wdata;
    logic        reg_wr;
    byte_type    reg_rdata;
    logic        hsync_pin;
    logic        clamp_pin;
    logic        clamp_out;
    logic        offset_cal_active;
    code_type    clamp_target_red;
    code_type    clamp_target_green;
    code_type    clamp_target_blue;
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [31:0] rnd;
    int          tn[5] = '{4, 0, 0, 255, 1};
    int          td[5] = '{40, 1, 0, 255, 2};

    clamp_timing_generator uut (
        .core_clk           (core_clk),
        .srst               (srst),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rdata          (reg_rdata),
        .hsync_pin          (hsync_pin),
        .clamp_pin          (clamp_pin),
        .clamp_out          (clamp_out),
        .offset_cal_active  (offset_cal_active),
        .clamp_target_red   (clamp_target_red),
        .clamp_target_green (clamp_target_green),
        .clamp_target_blue  (clamp_target_blue)
    );

    video_source src (
        .core_clk  (core_clk),
        .hsync_pin (hsync_pin),
        .clamp_pin (clamp_pin)
    );

    // --------------------------------------------------------------
    // clock, watchdog and helpers
    // --------------------------------------------------------------
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // longest run is a few thousand cycles; this only cuts a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            stop_test;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // pulse expected at edge k when it spans edges s .. s+len-1
    function automatic logic win(input int k, s, len);
        return k >= s && k < s + len;
    endfunction

    // offset window follows each clamp end, c0 adds an earlier one
    function automatic logic cal(input int k, s, len, c0);
        return (len > 0 && win(k, s + len + 1, 16)) ||
               (c0 > 0 && win(k, c0, 16));
    endfunction

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset;
        srst = 1'b1;
        repeat (3) tick;
        srst = 1'b0;
    endtask

    // strobe drops for a full cycle so back-to-back writes stay clean
    task automatic wr(input byte_type a, input byte_type d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick;
        reg_wr = 1'b0;
        tick;
    endtask

    task automatic chk_reg(input byte_type a, input byte_type e);
        reg_addr = a;
        tick;
        `CHK(reg_rdata, e)
    endtask

    // k counts edges from the last trailing sync edge, also in external mode
    task automatic watch(input int s, len, kmin, c0);
        for (int k = 1; k < s + len + 20; k++) begin
            tick;
            if (k >= kmin) begin
                `CHK(clamp_out, win(k, s, len))
                `CHK(offset_cal_active, cal(k, s, len, c0))
            end
        end
    endtask

    task automatic done(input string s);
        $display("%s finished", s);
    endtask

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic act;
        int   n;
        int   d;
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        rnd = 32'h1BFB4E60;
        do_reset;
        // random writes, one to an unmapped place, read back
        rnd = lfsr(rnd);
        wr(8'h18, rnd[7:0] & 8'hEE);
        wr(8'h19, rnd[15:8]);
        wr(8'h1A, rnd[23:16]);
        wr(8'h1B, rnd[31:24]);
        chk_reg(8'h18, rnd[7:0] & 8'hEE);
        chk_reg(8'h19, rnd[15:8]);
        chk_reg(8'h1A, rnd[23:16]);
        chk_reg(8'h1B, 8'h00);
        do_reset;
        chk_reg(8'h18, RST_CLAMP_CONFIGURATION);
        chk_reg(8'h19, RST_CLAMP_PLACEMENT_COUNT);
        chk_reg(8'h1A, RST_CLAMP_DURATION_COUNT);
        `CHK(clamp_out, 1'b0)
        `CHK(clamp_target_red, 10'h000)
        done("registers");
        // every select combination, one bit per channel
        for (int sel = 0; sel < 8; sel++) begin
            wr(8'h18, 8'(sel << 1));
            tick;
            `CHK(clamp_target_red, sel[2] ? 10'h200 : 10'h000)
            `CHK(clamp_target_green, sel[1] ? 10'h200 : 10'h000)
            `CHK(clamp_target_blue, sel[0] ? 10'h200 : 10'h000)
        end
        done("targets");
        // internal mode with the pin held at an active level
        src.set_level(1'b1);
        wr(8'h18, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            n = i < 5 ? tn[i] : int'(rnd[7:0]); // first line
            d = i < 5 ? td[i] : int'(rnd[15:8]);
            wr(8'h19, 8'(n));
            wr(8'h1A, 8'(d));
            src.sync_pulse(3);
            watch(3 + n, d, 1, 0);
        end
        done("internal");
        // second trailing edge in mid-pulse restarts placement
        wr(8'h19, 8'h04);
        wr(8'h1A, 8'h28);
        src.sync_pulse(3);
        repeat (20) tick;
        src.sync_pulse(2);
        watch(7, 40, 3, 4);
        done("restart");
        // external mode under all four polarity codes
        for (int pol = 0; pol < 4; pol++) begin
            rnd = lfsr(rnd);
            act = (pol == 2) ? 1'b0 : 1'b1;
            src.set_level(!act);
            wr(8'h18, 8'((pol << 6) | 8'h10));
            repeat (20) tick;
            src.sync_pulse(3);
            fork
                src.ext_clamp(act, 1 + int'(rnd[4:0]));
                watch(4, 1 + int'(rnd[4:0]), 1, 0);
            join
        end
        done("external");
        stop_test;
    end
endmodule

// [tb/video_source.sv]
`timescale 1ns/10ps
module video_source (
    // clock
    input  wire logic core_clk,
    // sync and clamp pins
    output logic      hsync_pin,
    output logic      clamp_pin
);
    // pins idle low until the bench starts a line
    initial begin
        hsync_pin = 1'b0;
        clamp_pin = 1'b0;
    end

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    // sync pulse; returns right after the trailing edge
    task automatic sync_pulse(input int width);
        tick;
        hsync_pin = 1'b1;
        repeat (width) tick;
        hsync_pin = 1'b0;
    endtask

    // park the clamp pin at a level, e.g. its idle level
    task automatic set_level(input logic v);
        tick;
        clamp_pin = v;
    endtask

    // back porch only
    // called after sync_pulse: one pixel of porch, then the clamp
    task automatic ext_clamp(input logic act, input int len);
        tick;
        clamp_pin = act;
        repeat (len) tick;
        clamp_pin = !act;
    endtask
endmodule
